// *** adc_readout_pkg.sv ***
// shared constants and types for the serial converter readout
package adc_readout_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_PERIOD_NS = 100;
  // internally timed conversion, counted on the block clock
  localparam int CONV_TIME_NS = 7500;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CONV_COUNT_W = 7;
  localparam logic [CONV_COUNT_W-1:0] CONV_LAST = CONV_COUNT_W'(CONV_CYCLES - 1);
  localparam logic [CONV_COUNT_W-1:0] CONV_COUNT_RESET = 7'h00;

  // ************************************************************
  // data path
  // ************************************************************
  localparam int RESULT_BITS = 10;
  localparam int RESULT_MSB = RESULT_BITS - 1;
  localparam int FIFO_DEPTH = 32;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;

  // ************************************************************
  // three-level power pin, as seen after the level comparators
  // ************************************************************
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_FLOAT = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;
  localparam logic [1:0] LEVEL_RESET = 2'h1;

  // ************************************************************
  // pin values after reset
  // ************************************************************
  localparam logic SELECT_RESET = 1'b1;
  localparam logic SCLK_RESET = 1'b0;
  localparam logic OUT_RESET = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_PUSH,
    ST_WAIT_DATA,
    ST_SHIFT
  } conv_state_e;

endpackage

// *** result_fifo.sv ***
// parameterised first-in first-out buffer with valid and ready on both sides
module result_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // write side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // read side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_s;

  fifo_s s_reg;
  fifo_s s_next;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign empty = (s_reg.wr_ptr == s_reg.rd_ptr);
  assign full = (s_reg.wr_ptr[AW] != s_reg.rd_ptr[AW]) &&
                (s_reg.wr_ptr[AW-1:0] == s_reg.rd_ptr[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = s_reg.mem[s_reg.rd_ptr[AW-1:0]];

  always_comb begin
    s_next = s_reg;
    if (in_valid_in && !full) begin
      s_next.mem[s_reg.wr_ptr[AW-1:0]] = in_data_in;
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (out_ready_in && !empty) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// *** adc_serial_readout.sv ***
// conversion control and serial readout of a 10-bit converter
//
// Overview of operation
// R01 - select falling edge starts a conversion and puts the sampler into hold
// R02 - select high keeps the serial output undriven
// R03 - serial output changes only on serial clock falling edges; the code drives the completion high without a clock edge
// R04 - host clocks readout at 2.1 MHz or slower, stopping allowed
// R05 - host keeps each serial clock phase at least 200 ns
// R06 - host keeps select high at least 1.5 us between conversions
// R07 - low power level input puts the device into power-down
// R08 - high or floating power level input means fully operational
// R09 - high level enables internal reference, floating level disables it
// R10 - completion shows as output high, then ten bits, most significant first
// R11 - host keeps serial clock idle during a conversion
// R12 - host raises select after last bit, ending the cycle
module adc_serial_readout
  import adc_readout_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // serial link pins from the host
  input wire logic select_n_in,
  input wire logic serial_clock_in,
  // serial result pin, three-state
  output logic serial_data_out,
  output logic serial_data_oe_out,
  // three-level power pin, as comparator outputs
  input wire logic [1:0] power_level_select_in,
  // analog front end
  input wire logic [RESULT_BITS-1:0] analog_input_in,
  output logic sampler_hold_out,
  // power and reference control
  output logic powered_down_out,
  output logic reference_enable_out
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic sel_meta;
    logic sel_sync;
    logic sel_prev;
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic [1:0] level_meta;
    logic [1:0] level_sync;
    logic [RESULT_BITS-1:0] analog_meta;
    logic [RESULT_BITS-1:0] analog_sync;
    conv_state_e state;
    logic [CONV_COUNT_W-1:0] count;
    logic [RESULT_BITS-1:0] sample;
    logic [RESULT_BITS-1:0] shift;
    logic data;
    logic data_oe;
    logic hold;
    logic powered_down;
    logic ref_enable;
  } readout_s;

  readout_s s_reg;
  readout_s s_next;

  logic sel_fall;
  logic sclk_fall;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [RESULT_BITS-1:0] fifo_out_data;

  assign sel_fall = s_reg.sel_prev && !s_reg.sel_sync;
  assign sclk_fall = s_reg.sclk_prev && !s_reg.sclk_sync;

  // ************************************************************
  // result buffer between converter and serialiser
  // ************************************************************
  // a pending push stalls the converter until the buffer has room
  assign fifo_in_valid = (s_reg.state == ST_PUSH);
  // the serialiser stalls draining while it shifts; any word left
  // from an aborted frame is dropped while idle
  assign fifo_out_ready = (s_reg.state != ST_SHIFT);

  result_fifo #(
    .WIDTH(RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(fifo_in_valid),
    .in_data_in(s_reg.sample),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;

    // pins cross into the block clock through two flip-flops
    s_next.sel_meta = select_n_in;
    s_next.sel_sync = s_reg.sel_meta;
    s_next.sel_prev = s_reg.sel_sync;
    // serial clock is sampled, so each phase must span two block cycles
    s_next.sclk_meta = serial_clock_in;
    s_next.sclk_sync = s_reg.sclk_meta;
    s_next.sclk_prev = s_reg.sclk_sync;
    s_next.level_meta = power_level_select_in;
    s_next.level_sync = s_reg.level_meta;
    // the converter word is sampled, not handshaken: it must stand still
    // for a few cycles around the select fall, or a torn word is taken
    s_next.analog_meta = analog_input_in;
    s_next.analog_sync = s_reg.analog_meta;

    s_next.powered_down = (s_reg.level_sync == LEVEL_LOW); // R07 R08
    s_next.ref_enable = (s_reg.level_sync == LEVEL_HIGH); // R09

    case (s_reg.state)
      ST_IDLE: begin
        s_next.data_oe = 1'b0; // R02
        s_next.data = OUT_RESET;
        s_next.hold = 1'b0;
        // conversions are refused while powered down
        if (sel_fall && !s_reg.powered_down) begin // R01 R08
          s_next.state = ST_CONVERT;
          s_next.count = CONV_COUNT_RESET;
          s_next.sample = s_reg.analog_sync;
          s_next.hold = 1'b1;
          s_next.data_oe = 1'b1;
          s_next.data = 1'b0;
        end
      end
      ST_CONVERT: begin
        // serial clock is ignored here; host keeps it idle
        if (s_reg.count == CONV_LAST) begin // R11
          s_next.state = ST_PUSH;
        end else begin
          s_next.count = s_reg.count + 1'b1;
        end
      end
      ST_PUSH: begin
        // a full buffer delays completion rather than losing a result
        if (fifo_in_ready) begin
          s_next.state = ST_WAIT_DATA;
          s_next.hold = 1'b0;
        end
      end
      ST_WAIT_DATA: begin
        // completion shows only once the word sits in the serialiser
        if (fifo_out_valid) begin
          s_next.state = ST_SHIFT;
          s_next.shift = fifo_out_data;
          s_next.data = 1'b1; // R10
        end
      end
      ST_SHIFT: begin
        // zeros follow once the ten bits are out
        if (sclk_fall) begin // R03
          s_next.data = s_reg.shift[RESULT_MSB]; // R10
          s_next.shift = {s_reg.shift[RESULT_MSB-1:0], 1'b0};
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase

    // select high or power-down ends any frame at once
    if (s_reg.state != ST_IDLE && (s_reg.sel_sync || s_reg.powered_down)) begin // R12
      s_next.state = ST_IDLE;
      s_next.data_oe = 1'b0; // R02
      s_next.data = OUT_RESET;
      s_next.hold = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg.sel_meta <= SELECT_RESET;
      s_reg.sel_sync <= SELECT_RESET;
      s_reg.sel_prev <= SELECT_RESET;
      s_reg.sclk_meta <= SCLK_RESET;
      s_reg.sclk_sync <= SCLK_RESET;
      s_reg.sclk_prev <= SCLK_RESET;
      s_reg.level_meta <= LEVEL_RESET;
      s_reg.level_sync <= LEVEL_RESET;
      s_reg.analog_meta <= RESULT_RESET;
      s_reg.analog_sync <= RESULT_RESET;
      s_reg.state <= ST_IDLE;
      s_reg.count <= CONV_COUNT_RESET;
      s_reg.sample <= RESULT_RESET;
      s_reg.shift <= RESULT_RESET;
      s_reg.data <= OUT_RESET;
      s_reg.data_oe <= OUT_RESET;
      s_reg.hold <= OUT_RESET;
      s_reg.powered_down <= OUT_RESET;
      s_reg.ref_enable <= OUT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs, all straight from flip-flops
  // ************************************************************
  assign serial_data_out = s_reg.data;
  assign serial_data_oe_out = s_reg.data_oe;
  assign sampler_hold_out = s_reg.hold;
  assign powered_down_out = s_reg.powered_down;
  assign reference_enable_out = s_reg.ref_enable;

endmodule

// *** adc_readout_sva.sv ***
// pin-level property checker for the converter readout
module adc_readout_sva
  import adc_readout_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic select_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_out,
  input wire logic [1:0] power_level_select_in,
  input wire logic sampler_hold_out,
  input wire logic powered_down_out,
  input wire logic reference_enable_out
);
  // ****
  // properties
  // ****
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  property p_start;
    $fell(select_n_in) && !serial_data_oe_out && !powered_down_out
      |-> ##4 sampler_hold_out && serial_data_oe_out;
  endproperty
  a_start: assert property (p_start) else $error("no hold after select fall");
  property p_release;
    select_n_in [*5] |-> !serial_data_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("pin driven while deselected");
  // three high samples: a change here can only follow a rising edge
  property p_shift;
    (serial_data_oe_out && serial_clock_in) [*3] |-> $stable(serial_data_out);
  endproperty
  a_shift: assert property (p_shift) else $error("data moved off a falling edge");
  property p_pdown;
    (power_level_select_in == LEVEL_LOW) [*5] |-> powered_down_out;
  endproperty
  a_pdown: assert property (p_pdown) else $error("low level not powered down");
  property p_oper;
    (power_level_select_in != LEVEL_LOW) [*5] |-> !powered_down_out;
  endproperty
  a_oper: assert property (p_oper) else $error("powered down while operational");
  property p_refon;
    (power_level_select_in == LEVEL_HIGH) [*5] |-> reference_enable_out;
  endproperty
  a_refon: assert property (p_refon) else $error("reference off at high level");
  property p_refoff;
    (power_level_select_in == LEVEL_FLOAT) [*5] |-> !reference_enable_out;
  endproperty
  a_refoff: assert property (p_refoff) else $error("reference on while floating");
  property p_eoc;
    $fell(sampler_hold_out) && serial_data_oe_out |=> serial_data_out;
  endproperty
  a_eoc: assert property (p_eoc) else $error("no completion bit");
endmodule

bind adc_serial_readout adc_readout_sva chk (.clock_in, .arst_n_in, .select_n_in,
  .serial_clock_in, .serial_data_out, .serial_data_oe_out, .power_level_select_in,
  .sampler_hold_out, .powered_down_out, .reference_enable_out);

// *** adc_host_model.sv ***
// host side of the three-wire readout link
module adc_host_model (
  input wire logic clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_oe_in,
  output logic select_n_out,
  output logic serial_clock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // frame driver
  // ****
  initial begin
    select_n_out = 1'b1;
    serial_clock_out = 1'b0;
  end
  // four block cycles: 400 ns phases, 800 ns period
  task automatic phase();
    repeat (4) @(negedge clock_in);
  endtask
  task automatic read_word(input int nbits, output logic [9:0] w, output logic eoc);
    int n;
    w = '0;
    n = 0;
    @(negedge clock_in);
    select_n_out = 1'b0;
    // clock stays idle until completion shows
    while (!(serial_data_oe_in && serial_data_in) && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    eoc = serial_data_oe_in & serial_data_in;
    for (int i = 0; i <= nbits && eoc; i++) begin
      phase();
      serial_clock_out = 1'b1;
      // undriven pin reads as the pull-up level
      if (i > 0) w = {w[8:0], serial_data_oe_in ? serial_data_in : 1'b1};
      phase();
      serial_clock_out = 1'b0;
    end
    phase();
    select_n_out = 1'b1;
    repeat (20) @(negedge clock_in);
  endtask
endmodule

// *** adc_serial_readout_test.sv ***
// self-checking bench for the converter readout
module adc_serial_readout_test;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_readout_pkg::*;
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
  // ****
  // wiring
  // ****
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic select_n, sclk, sdata, soe, hold, pdown, refen, eoc;
  logic [1:0] level = LEVEL_HIGH;
  logic [RESULT_BITS-1:0] analog_value = '0;
  logic held = 1'b0;
  logic [RESULT_BITS-1:0] w;
  logic [RESULT_BITS-1:0] exp_q[$];
  logic [15:0] seed = 16'h005f;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clock_in = ~clock_in;
  // remembers any hold seen since the frame cleared it
  always @(negedge clock_in) begin
    if (hold) begin
      held = 1'b1;
    end
  end
  adc_serial_readout DUT (.clock_in, .arst_n_in, .select_n_in(select_n),
    .serial_clock_in(sclk), .serial_data_out(sdata), .serial_data_oe_out(soe),
    .power_level_select_in(level), .analog_input_in(analog_value), .sampler_hold_out(hold),
    .powered_down_out(pdown), .reference_enable_out(refen));
  adc_host_model host (.clock_in, .serial_data_in(sdata), .serial_data_oe_in(soe),
    .select_n_out(select_n), .serial_clock_out(sclk));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one frame; the input value is held, the model keeps it queued
  task automatic frame(input logic [1:0] lv, input int nbits);
    @(negedge clock_in);
    level = lv;
    seed = lfsr(seed);
    analog_value = seed[9:0];
    exp_q.push_back(analog_value);
    repeat (10) @(negedge clock_in);
    held = 1'b0;
    host.read_word(nbits, w, eoc);
    `CHK("hold", lv != LEVEL_LOW, held)
    `CHK("power down", lv == LEVEL_LOW, pdown)
    `CHK("reference", lv == LEVEL_HIGH, refen)
    `CHK("completion", lv != LEVEL_LOW, eoc)
    `CHK("released", 1'b0, soe)
    if (eoc) `CHK("word", exp_q[$] >> (RESULT_BITS - nbits), w)
    exp_q.pop_front();
    $display("frame level %0d bits %0d done", lv, nbits);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (2) @(negedge clock_in);
    arst_n_in = 1'b1;
    for (int i = 0; i < 6; i++) frame(i[0] ? LEVEL_FLOAT : LEVEL_HIGH, 10);
    frame(LEVEL_HIGH, 3);
    frame(LEVEL_LOW, 10);
    frame(LEVEL_FLOAT, 10);
    frame(LEVEL_HIGH, 10);
    wrap_up();
  end
  // ten frames take about 1900 cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
endmodule
